// *** rtl/psc_pkg.sv ***
// package for the power supply control register bank
package psc_pkg;

  // register indices as printed (not all multiples of four; byte address = 4 * index)
  localparam logic [15:0] LCD_REGULATOR_CTRL_IDX = 16'h50a3;
  localparam logic [15:0] LCD_BOOSTER_CTRL_IDX = 16'h50a4;
  localparam logic [15:0] LOGIC_VOLTAGE_CTRL_IDX = 16'h5120;

  // bus and register widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // field positions
  localparam int LOGIC_VOLT_MODE_BIT = 0;
  localparam int LOGIC_HEAVY_LOAD_BIT = 4;
  localparam int LCD_HEAVY_LOAD_BIT = 4;
  localparam int BOOSTER_EN_BIT = 0;
  localparam int SOURCE_SEL_BIT = 1;

  // reset value of every implemented bit
  localparam logic RESET_BIT = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control outputs toward the analog circuits
  typedef struct packed {
    logic logic_volt_mode_sel;
    logic logic_reg_heavy_load_en;
    logic lcd_reg_heavy_load_en;
    logic booster_enable;
    logic lcd_reg_source_sel;
    logic lcd_drive_supply_en;
  } psc_ctrl_t;

endpackage : psc_pkg

// *** rtl/psc_regs.sv ***
// power supply control register bank with axi4-lite slave
// Behaviour
// RULE1: bit 0 of logic_voltage_ctrl picks flash mode (1) or normal mode (0), reset 0.
// RULE2: bit 4 of logic_voltage_ctrl turns logic regulator heavy-load protection on or off, reset 0.
// RULE3: bit 4 of lcd_regulator_ctrl turns lcd regulator heavy-load protection on or off, reset 0.
// RULE4: bit 0 of lcd_booster_ctrl switches the booster on or off, reset off.
// RULE5: bit 1 of lcd_booster_ctrl picks booster output (1) or main supply (0) for the lcd regulator.
// RULE6: software enables the booster and waits about 1 ms before selecting its output.
// RULE7: software sets flash mode only around flash erase or program.
// RULE8: software waits up to 5 ms after a mode change before programming flash.
// RULE9: lcd drive voltages reach the lcd driver only while the display-control field is nonzero.
// RULE10: with a main supply of 2.5 V or more software keeps booster enable and source select at 0.
// RULE11: with the lcd driver unused software clears booster enable, source select and display control.
// RULE12: each of the three registers is 8 bits wide at its own address.
// RULE13: software writes 0 to every reserved bit.
// RULE14: reserved bits ignore writes and read 0; implemented bits clear on reset.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module psc_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic [psc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [psc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [psc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [psc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // display-control field from the lcd driver
  input wire logic [1:0] display_control_field,
  // controls to the analog circuits
  output psc_pkg::psc_ctrl_t ctrl_q
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------

  // map a byte address to a register select, 0 means unmapped
  function automatic logic [1:0] decode(input logic [psc_pkg::ADDR_W-1:0] addr);
    logic [psc_pkg::ADDR_W-1:0] a_lcdr;
    logic [psc_pkg::ADDR_W-1:0] a_boost;
    logic [psc_pkg::ADDR_W-1:0] a_logic;
    a_lcdr = {psc_pkg::LCD_REGULATOR_CTRL_IDX, 2'h0};
    a_boost = {psc_pkg::LCD_BOOSTER_CTRL_IDX, 2'h0};
    a_logic = {psc_pkg::LOGIC_VOLTAGE_CTRL_IDX, 2'h0};
    if (addr == a_lcdr)
    begin
      decode = 2'h1;
    end
    else if (addr == a_boost)
    begin
      decode = 2'h2;
    end
    else if (addr == a_logic)
    begin
      decode = 2'h3;
    end
    else
    begin
      decode = 2'h0;
    end
  endfunction : decode

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------

  logic logic_volt_mode_sel_q;
  logic logic_reg_heavy_load_en_q;
  logic lcd_reg_heavy_load_en_q;
  logic booster_enable_q;
  logic lcd_reg_source_sel_q;

  // write channel state
  logic aw_held_q;
  logic w_held_q;
  logic [psc_pkg::ADDR_W-1:0] awaddr_q;
  logic [psc_pkg::DATA_W-1:0] wdata_q;
  logic wstrb0_q;
  logic do_write;
  logic [1:0] wsel;

  // two-stage sync of the display-control field from the lcd driver
  logic [1:0] dsp_meta_q;
  logic [1:0] dsp_sync_q;

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wsel = decode(awaddr_q);

  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------

  // accept address and data in either order, one write at a time
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !s_axi_wready && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped address
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= psc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wsel == 2'h0) ? psc_pkg::RESP_SLVERR : psc_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // implemented bits only; reserved positions are simply not stored
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      logic_volt_mode_sel_q <= psc_pkg::RESET_BIT; // [RULE1]
      logic_reg_heavy_load_en_q <= psc_pkg::RESET_BIT; // [RULE2]
      lcd_reg_heavy_load_en_q <= psc_pkg::RESET_BIT; // [RULE3]
      booster_enable_q <= psc_pkg::RESET_BIT; // [RULE4]
      lcd_reg_source_sel_q <= psc_pkg::RESET_BIT; // [RULE5] [RULE14]
    end
    else if (do_write && wstrb0_q)
    begin
      if (wsel == 2'h3)
      begin
        logic_volt_mode_sel_q <= wdata_q[psc_pkg::LOGIC_VOLT_MODE_BIT]; // [RULE1]
        logic_reg_heavy_load_en_q <= wdata_q[psc_pkg::LOGIC_HEAVY_LOAD_BIT]; // [RULE2]
      end
      else if (wsel == 2'h1)
      begin
        lcd_reg_heavy_load_en_q <= wdata_q[psc_pkg::LCD_HEAVY_LOAD_BIT]; // [RULE3]
      end
      else if (wsel == 2'h2)
      begin
        booster_enable_q <= wdata_q[psc_pkg::BOOSTER_EN_BIT]; // [RULE4]
        lcd_reg_source_sel_q <= wdata_q[psc_pkg::SOURCE_SEL_BIT]; // [RULE5]
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------

  // read image of the selected 8-bit register, reserved bits zero
  function automatic logic [psc_pkg::DATA_W-1:0] read_image(input logic [1:0] sel);
    logic [psc_pkg::REG_W-1:0] r;
    r = '0;
    if (sel == 2'h3)
    begin
      r[psc_pkg::LOGIC_VOLT_MODE_BIT] = logic_volt_mode_sel_q;
      r[psc_pkg::LOGIC_HEAVY_LOAD_BIT] = logic_reg_heavy_load_en_q;
    end
    else if (sel == 2'h1)
    begin
      r[psc_pkg::LCD_HEAVY_LOAD_BIT] = lcd_reg_heavy_load_en_q;
    end
    else if (sel == 2'h2)
    begin
      r[psc_pkg::BOOSTER_EN_BIT] = booster_enable_q;
      r[psc_pkg::SOURCE_SEL_BIT] = lcd_reg_source_sel_q;
    end
    read_image = {{(psc_pkg::DATA_W-psc_pkg::REG_W){1'b0}}, r}; // [RULE12] [RULE14]
  endfunction : read_image

  // one read at a time: arready pulses, data one cycle later
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= psc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_image(decode(s_axi_araddr));
        s_axi_rresp <= (decode(s_axi_araddr) == 2'h0) ? psc_pkg::RESP_SLVERR : psc_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------

  // synchronise the display-control field
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dsp_meta_q <= 2'h0;
      dsp_sync_q <= 2'h0;
    end
    else
    begin
      dsp_meta_q <= display_control_field;
      dsp_sync_q <= dsp_meta_q;
    end
  end

  // registered controls to the analog side
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= '0;
    end
    else
    begin
      ctrl_q.logic_volt_mode_sel <= logic_volt_mode_sel_q; // [RULE1]
      ctrl_q.logic_reg_heavy_load_en <= logic_reg_heavy_load_en_q; // [RULE2]
      ctrl_q.lcd_reg_heavy_load_en <= lcd_reg_heavy_load_en_q; // [RULE3]
      ctrl_q.booster_enable <= booster_enable_q; // [RULE4]
      ctrl_q.lcd_reg_source_sel <= lcd_reg_source_sel_q; // [RULE5]
      ctrl_q.lcd_drive_supply_en <= (dsp_sync_q != 2'h0); // [RULE9]
    end
  end

endmodule : psc_regs

`default_nettype wire

// *** tb/power_supply_control_regs_tb_top.sv ***
// self-checking bench for the power supply control register bank
`timescale 1ns/1ps
`default_nettype none
module power_supply_control_regs_tb_top;
  localparam logic [17:0] A_LOG = {psc_pkg::LOGIC_VOLTAGE_CTRL_IDX, 2'b00};
  localparam logic [17:0] A_LCD = {psc_pkg::LCD_REGULATOR_CTRL_IDX, 2'b00};
  localparam logic [17:0] A_BST = {psc_pkg::LCD_BOOSTER_CTRL_IDX, 2'b00};
  localparam logic [1:0] OK = psc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = psc_pkg::RESP_SLVERR;
  logic sys_clk, arst_n;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, display_control_field;
  psc_pkg::psc_ctrl_t ctrl_q;
  int fails, cmp_count;
  logic [17:0] addrs [3] = '{A_LOG, A_LCD, A_BST};
  psc_regs dut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .display_control_field, .ctrl_q);
  task automatic stop_test();
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask : chk
  // one clock edge with a bounded wait
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 40)
    begin
      fails++;
      stop_test();
    end
  endtask : tick
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        chk("bresp", 32'(s_axi_bresp), 32'(r));
        s_axi_bready <= 1'b0;
      end
    end
    while (s_axi_bready);
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
        s_axi_rready <= 1'b0;
      end
    end
    while (s_axi_rready);
  endtask : rd
  // free-running clock
  initial
  begin
    sys_clk = 1'b0;
    forever
      #5 sys_clk = ~sys_clk;
  end
  // main sequence
  initial
  begin
    {arst_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, display_control_field} = '0;
    // reset held at the top of each pass, released for the rest of the run after the second
    repeat (2)
    begin
      arst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      chk("ctrl", 32'(ctrl_q), 32'h0);
      foreach (addrs[i])
        rd(addrs[i], 32'h0, OK);
      // reserved bits of each 8-bit register written as 0, bus bits above them as 1
      wr(A_LOG, 32'hffffff11, 4'hf, OK);
      rd(A_LOG, 32'h11, OK);
      wr(A_LCD, 32'hffffff10, 4'hf, OK);
      rd(A_LCD, 32'h10, OK);
      wr(A_BST, 32'h1, 4'hf, OK);
      chk("ctrl", 32'(ctrl_q), 32'h3c);
      wr(A_BST, 32'hffffff03, 4'hf, OK);
      rd(A_BST, 32'h3, OK);
      chk("ctrl", 32'(ctrl_q), 32'h3e);
    end
    foreach (addrs[i])
    begin
      wr(addrs[i], 32'h0, 4'hf, OK);
      rd(addrs[i], 32'h0, OK);
    end
    chk("ctrl", 32'(ctrl_q), 32'h0);
    wr(A_LOG, 32'h11, 4'he, OK);
    rd(A_LOG, 32'h0, OK);
    wr(A_LOG + 18'h4, 32'hff, 4'hf, ERR);
    rd(A_LOG + 18'h4, 32'h0, ERR);
    rd(18'h050a4, 32'h0, ERR);
    chk("ctrl", 32'(ctrl_q), 32'h0);
    for (int f = 0; f < 4; f++)
    begin
      display_control_field <= 2'(f);
      repeat (4) @(posedge sys_clk);
      chk("drive", 32'(ctrl_q.lcd_drive_supply_en), 32'(f != 0));
    end
    stop_test();
  end
endmodule : power_supply_control_regs_tb_top
`default_nettype wire

// *** tb/psc_regs_properties.sv ***
// assertions for the power supply control register bank
`timescale 1ns/1ps
`default_nettype none
module psc_regs_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // bus
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // lcd field and controls
  input wire logic [1:0] display_control_field,
  input wire psc_pkg::psc_ctrl_t ctrl_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [17:0] ar_q;
  logic [1:0] up_q;
  // last read address, cycles since reset saturating at 3
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ar_q <= 18'h0;
      up_q <= 2'h0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
        ar_q <= s_axi_araddr;
      if (up_q != 2'h3)
        up_q <= up_q + 2'h1;
    end
  end
  wire logic is_log = (ar_q == {psc_pkg::LOGIC_VOLTAGE_CTRL_IDX, 2'b00});
  wire logic is_lcd = (ar_q == {psc_pkg::LCD_REGULATOR_CTRL_IDX, 2'b00});
  wire logic is_bst = (ar_q == {psc_pkg::LCD_BOOSTER_CTRL_IDX, 2'b00});
  // implemented bits of the addressed register
  wire logic [7:0] impl = is_log ? 8'h11 : is_lcd ? 8'h10 : is_bst ? 8'h03 : 8'h00;
  AST_RD_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rd drop");
  AST_WR_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("wr drop");
  AST_RD_WIDTH:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  AST_RSVD_ZERO:
    assert property (s_axi_rvalid |-> (s_axi_rdata[7:0] & ~impl) == 8'h0) else $error("reserved bit set");
  AST_LOG_READ:
    assert property (s_axi_rvalid && is_log |-> s_axi_rdata[4] == ctrl_q.logic_reg_heavy_load_en
      && s_axi_rdata[0] == ctrl_q.logic_volt_mode_sel) else $error("logic reg mismatch");
  AST_LCD_READ:
    assert property (s_axi_rvalid && is_lcd |-> s_axi_rdata[4] == ctrl_q.lcd_reg_heavy_load_en) else $error("lcd reg");
  AST_BST_READ:
    assert property (s_axi_rvalid && is_bst |-> s_axi_rdata[1:0] == {ctrl_q.lcd_reg_source_sel, ctrl_q.booster_enable})
      else $error("booster reg");
  AST_DRIVE:
    assert property (up_q == 2'h3 |-> ctrl_q.lcd_drive_supply_en == ($past(display_control_field, 3) != 2'h0))
      else $error("drive enable");
  AST_RESET_CLEAR:
    assert property ($rose(arst_n) |-> ctrl_q == '0) else $error("ctrl not cleared");
  AST_CTRL_ON_WRITE:
    assert property ($changed(ctrl_q[5:1]) |-> $past(s_axi_bvalid)) else $error("ctrl moved without write");
  // main scenarios
  COV_WR_OK: cover property (s_axi_bvalid && s_axi_bresp == psc_pkg::RESP_OKAY);
  COV_RD_ERR: cover property (s_axi_rvalid && s_axi_rresp == psc_pkg::RESP_SLVERR);
  COV_DRIVE: cover property ($rose(ctrl_q.lcd_drive_supply_en));
endmodule : psc_regs_properties
bind psc_regs psc_regs_properties u_props (.sys_clk, .arst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .display_control_field, .ctrl_q);
`default_nettype wire
